// ===== hdl/stpg_top.sv
// sector test pattern generator and checker
`timescale 1ns/100ps
`include "stpg_map.svh"
module stpg_top import stpg_pkg::*; (
    input  wire logic           core_clk,              // 40 MHz clock
    input  wire logic           reset_n,               // async reset, active low
    input  wire logic           write_pattern_launch,  // start write-file pattern
    input  wire logic           read_check_launch,     // start read-file check
    input  wire stpg_file_cfg_t file_cfg,              // file parameters
    input  wire logic           wr_fifo_nearly_full,   // write fifo nearly full
    output logic                wr_fifo_push,          // write fifo push
    output stpg_word_t          wr_fifo_push_word,     // write fifo data
    input  wire logic           rd_fifo_drained,       // read fifo empty
    input  wire stpg_word_t     rd_fifo_word,          // read fifo data
    output logic                rd_fifo_pop,           // read fifo pop
    output logic                write_transfer_active, // write in progress
    output logic                read_transfer_active,  // read in progress
    output logic                verify_mismatch,       // data check failed
    output stpg_word_t          mismatch_expected      // expected word of first fail
);
    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rst_pipe_q;
    logic       rst_n;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_pipe_q <= 2'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_q[1];

    // ****************************************
    // declarations
    // ****************************************
    stpg_state_t              state_q, state_d;
    logic [`STPG_BEAT_W-1:0]  beat_q, beat_d;
    logic [`STPG_BEAT_W-1:0]  final_q, final_d;
    logic [`STPG_ADDR_W-1:0]  sat_q, sat_d;
    logic [2:0]               patt_q, patt_d;
    stpg_word_t               lfsr_q, lfsr_d;
    logic                     push_q, push_d;
    stpg_word_t               push_word_q, push_word_d;
    logic                     pop_q, pop_d;
    logic                     wact_q, wact_d;
    logic                     ract_q, ract_d;
    logic                     miss_q, miss_d;
    stpg_word_t               miss_exp_q, miss_exp_d;
    logic [`STPG_SEC_W-1:0]   file_size_code_sectors;
    logic [`STPG_PROD_W-1:0]  total_sectors;
    logic [`STPG_POS_W-1:0]   pos;
    stpg_word_t               inc_word;
    stpg_word_t               patt_word;
    stpg_word_t               gen_word;
    logic                     start_wr, start_rd;
    logic                     gen_valid, gen_adv;
    logic                     rd_take, last_take, word_bad;
    logic                     buf_in_ready, buf_out_valid, buf_out_ready;
    stpg_word_t               buf_out_word;

    // ****************************************
    // file size decode
    // ****************************************
    always_comb begin
        file_size_code_sectors = `STPG_SEC_W'(1) << (`STPG_FILE_SIZE_CODE_SHIFT + 5'(file_cfg.size_code));
        total_sectors = `STPG_PROD_W'(file_cfg.length) * `STPG_PROD_W'(file_size_code_sectors);
        start_wr      = (state_q == STPG_IDLE) & write_pattern_launch;
        start_rd      = (state_q == STPG_IDLE) & ~write_pattern_launch & read_check_launch;
    end

    // ****************************************
    // pattern generator
    // ****************************************
    always_comb begin
        pos = beat_q[`STPG_POS_W-1:0];
        inc_word = {sat_q[`STPG_WORD_W-`STPG_POS_W-1:0], pos};
        case (patt_q)
            `STPG_PATT_INC:  patt_word = inc_word;
            `STPG_PATT_DEC:  patt_word = ~inc_word;
            `STPG_PATT_ZERO: patt_word = 32'h00000000;
            `STPG_PATT_ONE:  patt_word = 32'hffffffff;
            `STPG_PATT_LFSR: patt_word = lfsr_q;
            default:         patt_word = inc_word;
        endcase
        if (pos == `STPG_HDR0_POS) begin
            gen_word = sat_q[31:0];
        end else if (pos == `STPG_HDR1_POS) begin
            // upper header bits in word 1
            gen_word = sat_q[63:32];
        end else begin
            gen_word = patt_word;
        end
    end

    // ****************************************
    // write data path
    // ****************************************
    always_comb begin
        gen_valid     = (state_q == STPG_WRITE) & (beat_q != final_q);
        // drain only while not nearly full
        buf_out_ready = ~wr_fifo_nearly_full;
        push_d        = buf_out_valid & buf_out_ready;
        push_word_d   = buf_out_word;
    end

    stpg_pair_buf stpg_pair_buf_inst (
        .clk       (core_clk),
        .rst_n     (rst_n),
        .in_valid  (gen_valid),
        .in_ready  (buf_in_ready),
        .in_word   (gen_word),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_word  (buf_out_word)
    );

    // ****************************************
    // read check path
    // ****************************************
    always_comb begin
        rd_take   = (state_q == STPG_READ) & pop_q & ~rd_fifo_drained;
        last_take = rd_take & (beat_q == final_q - `STPG_BEAT_W'(1));
        pop_d     = (state_q == STPG_READ) & ~rd_fifo_drained & ~last_take
                    & (beat_q != final_q);
        word_bad  = rd_take & (rd_fifo_word != gen_word);
        gen_adv   = (gen_valid & buf_in_ready) | rd_take;
    end

    // ****************************************
    // control and counters
    // ****************************************
    always_comb begin
        state_d    = state_q;
        beat_d     = beat_q;
        final_d    = final_q;
        sat_d      = sat_q;
        patt_d     = patt_q;
        lfsr_d     = lfsr_q;
        miss_d     = miss_q;
        miss_exp_d = miss_exp_q;
        if (start_wr || start_rd) begin
            state_d    = start_wr ? STPG_WRITE : STPG_READ;
            beat_d     = '0;
            miss_d     = 1'b0;
            miss_exp_d = 32'h00000000;
            final_d    = {total_sectors, `STPG_POS_W'(0)};
            sat_d      = `STPG_ADDR_W'(`STPG_PROD_W'(file_cfg.index)
                         * `STPG_PROD_W'(file_size_code_sectors));
            patt_d     = file_cfg.pattern;
            lfsr_d     = `STPG_LFSR_RST;
        end else begin
            if (gen_adv) begin
                beat_d = beat_q + `STPG_BEAT_W'(1);
                if (pos == `STPG_LAST_POS) begin
                    sat_d = sat_q + `STPG_ADDR_W'(1);
                end
                if (pos == `STPG_HDR0_POS) begin
                    lfsr_d = sat_q[31:0];
                end else begin
                    lfsr_d = {lfsr_q[30:0], lfsr_q[`STPG_TAP_A] ^ lfsr_q[`STPG_TAP_B]
                              ^ lfsr_q[`STPG_TAP_C]};
                end
            end
            if (word_bad) begin
                miss_d = 1'b1;
                if (!miss_q) begin
                    miss_exp_d = gen_word;
                end
            end
            case (state_q)
                STPG_WRITE: begin
                    if (beat_q == final_q && !buf_out_valid) begin
                        state_d = STPG_IDLE;
                    end
                end
                STPG_READ: begin
                    if (beat_q == final_q) begin
                        state_d = STPG_IDLE;
                    end
                end
                default: begin
                    state_d = STPG_IDLE;
                end
            endcase
        end
        wact_d = (state_d == STPG_WRITE);
        ract_d = (state_d == STPG_READ);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= STPG_IDLE;
            beat_q      <= '0;
            final_q     <= '0;
            sat_q       <= '0;
            patt_q      <= `STPG_PATT_INC;
            lfsr_q      <= `STPG_LFSR_RST;
            push_q      <= 1'b0;
            push_word_q <= 32'h00000000;
            pop_q       <= 1'b0;
            wact_q      <= 1'b0;
            ract_q      <= 1'b0;
            miss_q      <= 1'b0;
            miss_exp_q  <= 32'h00000000;
        end else begin
            state_q     <= state_d;
            beat_q      <= beat_d;
            final_q     <= final_d;
            sat_q       <= sat_d;
            patt_q      <= patt_d;
            lfsr_q      <= lfsr_d;
            push_q      <= push_d;
            push_word_q <= push_word_d;
            pop_q       <= pop_d;
            wact_q      <= wact_d;
            ract_q      <= ract_d;
            miss_q      <= miss_d;
            miss_exp_q  <= miss_exp_d;
        end
    end

    assign wr_fifo_push          = push_q;
    assign wr_fifo_push_word     = push_word_q;
    assign rd_fifo_pop           = pop_q;
    assign write_transfer_active = wact_q;
    assign read_transfer_active  = ract_q;
    assign verify_mismatch       = miss_q;
    assign mismatch_expected     = miss_exp_q;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_launch_raises_active: assert property (
        (state_q == STPG_IDLE && write_pattern_launch && file_cfg.length != 16'h0000)
        |=> write_transfer_active [*2])
        else $error("write launch did not raise active flag");

    a_push_when_room: assert property (
        wr_fifo_push |-> $past(!wr_fifo_nearly_full) && $past(state_q == STPG_WRITE))
        else $error("push while nearly full or not writing");

    a_beat_step: assert property (
        (gen_adv && !start_wr && !start_rd) |=> beat_q == $past(beat_q) + 1'b1)
        else $error("beat counter did not step");

    a_write_end: assert property (
        (state_q == STPG_WRITE && beat_q == final_q && !buf_out_valid)
        |=> !write_transfer_active ##1 !wr_fifo_push)
        else $error("write did not end at final count");

    a_final_count: assert property (
        start_wr |=> final_q == {$past(total_sectors), 7'h00})
        else $error("final count not length times size");

    a_pop_not_empty: assert property (
        rd_fifo_pop |-> $past(!rd_fifo_drained) && read_transfer_active)
        else $error("pop without available word");

    a_tracker_start: assert property (
        (start_wr || start_rd)
        |=> sat_q == (64'($past(file_cfg.index))
                      << (`STPG_FILE_SIZE_CODE_SHIFT + 5'($past(file_cfg.size_code)))))
        else $error("tracker start value wrong");

    a_header_zero: assert property (
        (gen_adv && pos == 7'h00) |-> gen_word == sat_q[31:0])
        else $error("header word 0 not tracker");

    a_sector_step: assert property (
        (gen_adv && pos == 7'h7f) |=> sat_q == $past(sat_q) + 1'b1)
        else $error("tracker did not step after sector");

    a_decrement_form: assert property (
        (pos > 7'h01 && patt_q == 3'h1) |-> gen_word == ~{sat_q[24:0], pos})
        else $error("decrement pattern wrong");

    a_lfsr_seed: assert property (
        (gen_adv && pos == 7'h00 && !start_rd) |=> lfsr_q == $past(sat_q[31:0]))
        else $error("lfsr not seeded from header");

    a_zero_ones: assert property (
        (pos > 7'h01 && patt_q[2:1] == 2'h1) |-> gen_word == {32{patt_q[0]}})
        else $error("constant pattern wrong");

    a_mismatch_set: assert property (
        (rd_take && rd_fifo_word != gen_word) |=> verify_mismatch)
        else $error("mismatch not flagged");

    a_mismatch_hold: assert property (
        (verify_mismatch && !start_wr && !start_rd) |=> verify_mismatch)
        else $error("mismatch flag dropped early");

    c_write_done: cover property (write_transfer_active ##1 !write_transfer_active);
    c_read_done: cover property (read_transfer_active ##1 !read_transfer_active);
    c_paused: cover property (write_transfer_active && wr_fifo_nearly_full && buf_out_valid);
    c_mismatch: cover property ($rose(verify_mismatch));
endmodule : stpg_top

// ===== hdl/stpg_map.svh
// constants of the sector test pattern generator
`ifndef STPG_MAP_SVH
`define STPG_MAP_SVH

`define STPG_WORD_W      32
`define STPG_POS_W       7
`define STPG_LAST_POS    7'h7f
`define STPG_HDR0_POS    7'h00
`define STPG_HDR1_POS    7'h01
`define STPG_BEAT_W      42
`define STPG_SEC_W       19
`define STPG_ADDR_W      64
`define STPG_PROD_W      35
`define STPG_FILE_SIZE_CODE_SHIFT 5'h0b
`define STPG_PATT_INC    3'h0
`define STPG_PATT_DEC    3'h1
`define STPG_PATT_ZERO   3'h2
`define STPG_PATT_ONE    3'h3
`define STPG_PATT_LFSR   3'h4
`define STPG_TAP_A       30
`define STPG_TAP_B       20
`define STPG_TAP_C       0
`define STPG_LFSR_RST    32'h00000000

`endif

// ===== hdl/stpg_pkg.sv
// types of the sector test pattern generator
package stpg_pkg;

    typedef logic [31:0] stpg_word_t;

    typedef enum logic [1:0] {
        STPG_IDLE,
        STPG_WRITE,
        STPG_READ
    } stpg_state_t;

    typedef struct packed {
        logic [15:0] index;
        logic [15:0] length;
        logic [2:0]  size_code;
        logic [2:0]  pattern;
    } stpg_file_cfg_t;

endpackage : stpg_pkg

// ===== hdl/stpg_pair_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module stpg_pair_buf import stpg_pkg::*; (
    input  wire logic       clk,       // core clock
    input  wire logic       rst_n,     // synchronised reset, active low
    input  wire logic       in_valid,  // word offered
    output logic            in_ready,  // room for a word
    input  wire stpg_word_t in_word,   // word in
    output logic            out_valid, // word available
    input  wire logic       out_ready, // drain side takes a word
    output stpg_word_t      out_word   // oldest word
);
    stpg_word_t mem_q [2];
    stpg_word_t mem_d [2];
    logic       wr_ptr_q, wr_ptr_d;
    logic       rd_ptr_q, rd_ptr_d;
    logic [1:0] count_q, count_d;
    logic       push, pop;

    always_comb begin
        in_ready  = (count_q != 2'h2);
        out_valid = (count_q != 2'h0);
        out_word  = mem_q[rd_ptr_q];
        push      = in_valid & in_ready;
        pop       = out_valid & out_ready;
        mem_d     = mem_q;
        wr_ptr_d  = wr_ptr_q ^ push;
        rd_ptr_d  = rd_ptr_q ^ pop;
        count_d   = count_q + {1'b0, push} - {1'b0, pop};
        if (push) begin
            mem_d[wr_ptr_q] = in_word;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_q[0] <= 32'h00000000;
            mem_q[1] <= 32'h00000000;
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end else begin
            mem_q    <= mem_d;
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q  <= count_d;
        end
    end
endmodule : stpg_pair_buf

// ===== verification/stpg_fifo_model.sv
// behavioural write and read fifos on the far side of the generator
`timescale 1ns/100ps
module stpg_fifo_model import stpg_pkg::*; #(
    parameter int DEPTH = 16
) (
    input  wire logic  clk,                 // core clock
    input  wire logic  slow_drain,          // drain one word in four cycles
    input  wire logic  wr_fifo_push,        // push from generator
    output logic       wr_fifo_nearly_full, // two slots or fewer left
    output logic       overflow_seen,       // push into a full fifo
    input  wire logic  rd_fifo_pop,         // pop from checker
    output logic       rd_fifo_drained,     // read fifo empty
    output stpg_word_t rd_fifo_word         // head word, inverted last word when empty
);
    int         wr_cnt;
    int         tick;
    stpg_word_t rd_q[$];
    stpg_word_t head;

    initial begin
        wr_cnt          = 0;
        tick            = 0;
        overflow_seen   = 1'b0;
        rd_fifo_drained = 1'b1;
        rd_fifo_word    = 32'h00000000;
    end

    // flag leaves slack for the one-cycle reaction lag
    assign wr_fifo_nearly_full = (wr_cnt >= DEPTH - 2);

    always @(posedge clk) begin
        tick <= tick + 1;
        if (wr_fifo_push && wr_cnt >= DEPTH) begin
            overflow_seen <= 1'b1;
        end
        wr_cnt <= wr_cnt + int'(wr_fifo_push && wr_cnt < DEPTH)
                  - int'(wr_cnt > 0 && (!slow_drain || tick % 4 == 0));
        if (rd_fifo_pop && rd_q.size() > 0) begin
            head = rd_q.pop_front();
            rd_fifo_drained <= (rd_q.size() == 0);
            rd_fifo_word    <= (rd_q.size() == 0) ? ~head : rd_q[0];
        end
    end

    task automatic load_word(input stpg_word_t w);
        rd_q.push_back(w);
        rd_fifo_drained = 1'b0;
        rd_fifo_word    = rd_q[0];
    endtask : load_word
endmodule : stpg_fifo_model

// ===== verification/stpg_top_tb.sv
// self-checking bench of the sector test pattern generator
`timescale 1ns/100ps
`define CHECK(what, exp, got) \
    begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("unexpected %s: expected %h, seen %h", what, exp, got); end end
module stpg_top_tb import stpg_pkg::*;;
    logic           core_clk = 1'b0;
    logic           reset_n = 1'b0;
    logic           write_pattern_launch = 1'b0;
    logic           read_check_launch = 1'b0;
    stpg_file_cfg_t file_cfg = '0;
    logic           slow_drain = 1'b0;
    logic           wr_fifo_nearly_full, wr_fifo_push, rd_fifo_drained, rd_fifo_pop;
    logic           write_transfer_active, read_transfer_active, verify_mismatch;
    logic           overflow_seen;
    stpg_word_t     wr_fifo_push_word, rd_fifo_word, mismatch_expected;
    int             num_errors = 0;
    int             samples_checked = 0;
    int             mon_n = 0;
    logic           mon_on = 1'b0;
    logic           prev_nf = 1'b0;
    logic [63:0]    mon_start = '0;
    logic [2:0]     mon_pat = '0;
    logic [15:0]    idx_tab [6] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'hffff};
    logic [2:0]     sc_tab [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h0, 3'h7};

    always #12.5 core_clk = ~core_clk;

    stpg_top stpg_top_inst (.core_clk(core_clk), .reset_n(reset_n),
        .write_pattern_launch(write_pattern_launch), .read_check_launch(read_check_launch),
        .file_cfg(file_cfg), .wr_fifo_nearly_full(wr_fifo_nearly_full),
        .wr_fifo_push(wr_fifo_push), .wr_fifo_push_word(wr_fifo_push_word),
        .rd_fifo_drained(rd_fifo_drained), .rd_fifo_word(rd_fifo_word),
        .rd_fifo_pop(rd_fifo_pop), .write_transfer_active(write_transfer_active),
        .read_transfer_active(read_transfer_active), .verify_mismatch(verify_mismatch),
        .mismatch_expected(mismatch_expected));

    stpg_fifo_model stpg_fifo_model_inst (.clk(core_clk), .slow_drain(slow_drain),
        .wr_fifo_push(wr_fifo_push), .wr_fifo_nearly_full(wr_fifo_nearly_full),
        .overflow_seen(overflow_seen), .rd_fifo_pop(rd_fifo_pop),
        .rd_fifo_drained(rd_fifo_drained), .rd_fifo_word(rd_fifo_word));

    // ************************************************************
    // expected words and bus tasks
    // ************************************************************
    function automatic stpg_word_t exp_word(input logic [63:0] start, input int n,
                                            input logic [2:0] pat);
        logic [63:0] trk;
        logic [6:0]  pos;
        stpg_word_t  lf;
        trk = start + 64'(n / 128);
        pos = 7'(n % 128);
        lf  = trk[31:0];
        if (pos == 7'h00) return trk[31:0];
        if (pos == 7'h01) return trk[63:32];
        for (int k = 2; k <= int'(pos); k++) lf = {lf[30:0], lf[30] ^ lf[20] ^ lf[0]};
        case (pat)
            3'h1: return ~{trk[24:0], pos};
            3'h2: return 32'h00000000;
            3'h3: return 32'hffffffff;
            3'h4: return lf;
            default: return {trk[24:0], pos};
        endcase
    endfunction : exp_word

    // checks every pushed word and the pause after nearly-full
    always @(posedge core_clk) begin
        prev_nf <= wr_fifo_nearly_full;
        if (mon_on && prev_nf) `CHECK("paused push", 1'b0, wr_fifo_push)
        if (mon_on && wr_fifo_push) begin
            `CHECK("push word", exp_word(mon_start, mon_n, mon_pat), wr_fifo_push_word)
            mon_n++;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask : tick

    task automatic do_reset;
        reset_n = 1'b0;
        tick(8);
        reset_n = 1'b1;
        tick(3);
    endtask : do_reset

    task automatic launch(input logic wr, input stpg_file_cfg_t cfg);
        tick(1);
        file_cfg             = cfg;
        write_pattern_launch = wr;
        read_check_launch    = !wr;
        tick(1);
        write_pattern_launch = 1'b0;
        read_check_launch    = 1'b0;
    endtask : launch

    task automatic wait_drained;
        int guard;
        guard = 0;
        while (!rd_fifo_drained && guard < 1000) begin
            tick(1);
            guard++;
        end
        tick(3);
        `CHECK("read fifo drained", 1'b1, rd_fifo_drained)
    endtask : wait_drained

    // ************************************************************
    // tests
    // ************************************************************
    task automatic run_write(input logic [15:0] idx, input logic [2:0] sc,
                             input logic [2:0] pat, input logic slow);
        int guard;
        guard      = 0;
        mon_start  = 64'(idx) << (11 + sc);
        mon_pat    = pat;
        mon_n      = 0;
        slow_drain = slow;
        mon_on     = 1'b1;
        launch(1'b1, '{index: idx, length: 16'h0001, size_code: sc, pattern: pat});
        `CHECK("write active", 1'b1, write_transfer_active)
        read_check_launch = 1'b1;
        tick(1);
        read_check_launch = 1'b0;
        tick(1);
        `CHECK("read active while busy", 1'b0, read_transfer_active)
        while (mon_n < 260 && guard < 5000) begin
            tick(1);
            guard++;
        end
        `CHECK("words pushed", 1'b1, mon_n >= 260)
        `CHECK("write active midway", 1'b1, write_transfer_active)
        `CHECK("fifo overflow", 1'b0, overflow_seen)
        mon_on = 1'b0;
        do_reset;
        `CHECK("write active after reset", 1'b0, write_transfer_active)
        $display("write test with pattern %0d done", pat);
    endtask : run_write

    task automatic run_read(input logic [15:0] idx, input logic [2:0] sc,
                            input logic [2:0] pat);
        logic [63:0] start;
        start = 64'(idx) << (11 + sc);
        launch(1'b0, '{index: idx, length: 16'h0001, size_code: sc, pattern: pat});
        `CHECK("read active", 1'b1, read_transfer_active)
        for (int n = 0; n < 200; n++) begin
            stpg_fifo_model_inst.load_word(exp_word(start, n, pat));
            if (n % 50 == 49) begin
                tick(1);
                `CHECK("pop with words waiting", 1'b1, rd_fifo_pop)
                tick(n == 99 ? 80 : 4);
            end
        end
        wait_drained;
        `CHECK("mismatch on good data", 1'b0, verify_mismatch)
        `CHECK("pop when empty", 1'b0, rd_fifo_pop)
        stpg_fifo_model_inst.load_word(exp_word(start, 200, pat) ^ 32'h00000001);
        wait_drained;
        `CHECK("mismatch on bad word", 1'b1, verify_mismatch)
        `CHECK("expected of bad word", exp_word(start, 200, pat), mismatch_expected)
        stpg_fifo_model_inst.load_word(exp_word(start, 201, pat));
        wait_drained;
        `CHECK("mismatch held", 1'b1, verify_mismatch)
        do_reset;
        `CHECK("mismatch after reset", 1'b0, verify_mismatch)
        $display("read test with pattern %0d done", pat);
    endtask : run_read

    task automatic run_empty(input logic wr);
        launch(wr, '{index: 16'h0001, length: 16'h0000, size_code: 3'h0, pattern: 3'h0});
        `CHECK("empty active", 1'b1, wr ? write_transfer_active : read_transfer_active)
        tick(1);
        `CHECK("empty ended", 1'b0, wr ? write_transfer_active : read_transfer_active)
        `CHECK("empty push", 1'b0, wr_fifo_push)
        `CHECK("empty pop", 1'b0, rd_fifo_pop)
        $display("zero length command test done");
    endtask : run_empty

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        do_reset;
        for (int p = 0; p < 6; p++) begin
            run_write(idx_tab[p], sc_tab[p], 3'(p), p[0]);
        end
        run_read(16'h0003, 3'h1, 3'h4);
        run_read(16'hffff, 3'h7, 3'h1);
        run_empty(1'b1);
        run_empty(1'b0);
        tally_and_finish;
    end

    initial begin
        repeat (50000) @(posedge core_clk);
        num_errors++;
        $display("watchdog expired");
        tally_and_finish;
    end
endmodule : stpg_top_tb
